// file: design/tpi_regs.vh
`ifndef TPI_REGS_VH
`define TPI_REGS_VH
// register indices, host write port address space
`define TPI_ADDR_W 6
`define TPI_A_S_START_FIX 6'h00
`define TPI_A_T_START_FIX 6'h01
`define TPI_A_W_START_FIX 6'h02
`define TPI_A_Z_START_FIX 6'h03
`define TPI_A_S_START_FLT 6'h04
`define TPI_A_T_START_FLT 6'h05
`define TPI_A_W_START_FLT 6'h06
`define TPI_A_Z_START_FLT 6'h07
// index groups by bits 5:3, in gradient groups low 3 bits pick the parameter r,g,b,a,z,s,t,w
`define TPI_G_START 3'h0
`define TPI_G_GX_FIX 3'h2
`define TPI_G_GX_FLT 3'h3
`define TPI_G_CTRL 3'h4
`define TPI_G_GY_FIX 3'h5
`define TPI_G_GY_FLT 3'h6
`define TPI_A_CMD_FIX 6'h20
`define TPI_A_CMD_FLT 6'h21
`define TPI_A_PERSP 6'h22
// parameter indices
`define TPI_P_R 3'h0
`define TPI_P_G 3'h1
`define TPI_P_B 3'h2
`define TPI_P_A 3'h3
`define TPI_P_Z 3'h4
`define TPI_P_S 3'h5
`define TPI_P_T 3'h6
`define TPI_P_W 3'h7
// fraction bits per format
`define TPI_FRAC_CLR 6'h0c
`define TPI_FRAC_Z 6'h0c
`define TPI_FRAC_ST 6'h12
`define TPI_FRAC_W 6'h1e
`define TPI_CMD_SIGN_BIT 31
// steps
`define TPI_STEP_RIGHT 2'h0
`define TPI_STEP_LEFT 2'h1
`define TPI_STEP_DOWN 2'h2
`define TPI_STEP_UP 2'h3
`endif

// file: design/tpi_core.v
`include "tpi_regs.vh"
`default_nettype none
module tpi_core (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // host write port from bus fifo
  input wire wr_en_i,
  input wire [5:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  // vertices in 12.4, passed with the triangle
  input wire [15:0] vtx_ax_i,
  input wire [15:0] vtx_ay_i,
  // rasterizer step interface
  input wire step_en_i,
  input wire [1:0] step_dir_i,
  input wire tri_done_i,
  // triangle launch
  output reg tri_start_o,
  output reg tri_busy_o,
  output reg tri_cw_o,
  output reg [15:0] tri_ax_o,
  output reg [15:0] tri_ay_o,
  // iterated parameters
  output reg [23:0] red_o,
  output reg [23:0] green_o,
  output reg [23:0] blue_o,
  output reg [23:0] alpha_o,
  output reg [31:0] depth_o,
  output reg [31:0] tex_s_o,
  output reg [31:0] tex_t_o,
  output reg [31:0] recip_w_o
);

  reg rst_m_r;
  reg rst_n_r;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // fraction bits of parameter p
  function [5:0] frac_of;
    input [2:0] p;
    begin
      case (p)
        `TPI_P_Z: frac_of = `TPI_FRAC_Z;
        `TPI_P_S, `TPI_P_T: frac_of = `TPI_FRAC_ST;
        `TPI_P_W: frac_of = `TPI_FRAC_W;
        default: frac_of = `TPI_FRAC_CLR;
      endcase
    end
  endfunction

  // ieee single to 32-bit two's complement with fb fraction bits
  function [31:0] flt2fix;
    input [31:0] f;
    input [5:0] fb;
    reg [8:0] sh;
    reg [55:0] mag;
    reg [31:0] m;
    begin
      sh = 9'h000;
      mag = 56'h0;
      m = 32'h0;
      if (f[30:23] != 8'h00) begin
        // value = 1.m * 2^(e-127); fixed = 1.m<<23 * 2^(e-127-23+fb)
        if ({1'b0, f[30:23]} + {3'h0, fb} >= 9'd150) begin
          sh = {1'b0, f[30:23]} + {3'h0, fb} - 9'd150;
          mag = (sh > 9'd32) ? 56'h0 : ({32'h0, 1'b1, f[22:0]} << sh);
        end else begin
          sh = 9'd150 - {1'b0, f[30:23]} - {3'h0, fb};
          mag = (sh > 9'd24) ? 56'h0 : ({32'h0, 1'b1, f[22:0]} >> sh);
        end
        m = mag[31:0];
      end
      flt2fix = f[31] ? (32'h0 - m) : m;
    end
  endfunction

  // sign extend stored value by width of parameter
  function [31:0] sx;
    input [31:0] v;
    input [2:0] p;
    begin
      if (p < `TPI_P_Z)
        sx = {{8{v[23]}}, v[23:0]};
      else
        sx = v;
    end
  endfunction

  reg [31:0] start_r [0:7];
  reg [31:0] gx_r [0:7];
  reg [31:0] gy_r [0:7];
  reg [31:0] fgx_r [0:7];
  reg [31:0] fgy_r [0:7];
  reg [31:0] acc_r [0:7];
  reg persp_r;
  integer i;

  // write kinds
  localparam K_NONE = 3'h0;
  localparam K_START_FIX = 3'h1;
  localparam K_START_FLT = 3'h2;
  localparam K_GX_FIX = 3'h3;
  localparam K_GX_FLT = 3'h4;
  localparam K_GY_FIX = 3'h5;
  localparam K_GY_FLT = 3'h6;
  localparam K_CTRL = 3'h7;

  // classify a register index
  function [2:0] wr_kind;
    input [5:0] a;
    begin
      case (a[5:3])
        `TPI_G_START: begin
          if (a[2])
            wr_kind = K_START_FLT;
          else
            wr_kind = K_START_FIX;
        end
        `TPI_G_GX_FIX: wr_kind = K_GX_FIX;
        `TPI_G_GX_FLT: wr_kind = K_GX_FLT;
        `TPI_G_CTRL: wr_kind = K_CTRL;
        `TPI_G_GY_FIX: wr_kind = K_GY_FIX;
        `TPI_G_GY_FLT: wr_kind = K_GY_FLT;
        default: wr_kind = K_NONE;
      endcase
    end
  endfunction

  // start index to parameter slot
  function [2:0] start_slot;
    input [1:0] a;
    begin
      case (a)
        2'h0: start_slot = `TPI_P_S;
        2'h1: start_slot = `TPI_P_T;
        2'h2: start_slot = `TPI_P_W;
        default: start_slot = `TPI_P_Z;
      endcase
    end
  endfunction

  wire [2:0] kind = wr_kind(wr_addr_i);
  wire [2:0] gp = wr_addr_i[2:0];
  wire [2:0] sp = start_slot(wr_addr_i[1:0]);
  wire is_cmd = (wr_addr_i == `TPI_A_CMD_FIX) || (wr_addr_i == `TPI_A_CMD_FLT);
  wire accept = wr_en_i && is_cmd && !tri_busy_o;

  // write strobes per register kind
  wire wr_start_fix = wr_en_i && (kind == K_START_FIX);
  wire wr_start_flt = wr_en_i && (kind == K_START_FLT);
  wire wr_gx_fix = wr_en_i && (kind == K_GX_FIX);
  wire wr_gx_flt = wr_en_i && (kind == K_GX_FLT);
  wire wr_gy_fix = wr_en_i && (kind == K_GY_FIX);
  wire wr_gy_flt = wr_en_i && (kind == K_GY_FLT);
  wire wr_persp = wr_en_i && (kind == K_CTRL) && (wr_addr_i == `TPI_A_PERSP);

  // register writes; gradients copied into frozen working set on accept
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      persp_r <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        start_r[i] <= 32'h0;
        gx_r[i] <= 32'h0;
        gy_r[i] <= 32'h0;
      end
    end else begin
      if (wr_start_fix)
        start_r[sp] <= wr_data_i;
      if (wr_start_flt)
        start_r[sp] <= flt2fix(wr_data_i, frac_of(sp));
      if (wr_gx_fix)
        gx_r[gp] <= sx(wr_data_i, gp);
      if (wr_gx_flt)
        gx_r[gp] <= flt2fix(wr_data_i, frac_of(gp));
      if (wr_gy_fix)
        gy_r[gp] <= sx(wr_data_i, gp);
      if (wr_gy_flt)
        gy_r[gp] <= flt2fix(wr_data_i, frac_of(gp));
      if (wr_persp)
        persp_r <= wr_data_i[0];
    end
  end

  // one accumulator step in the given direction
  function [31:0] step_acc;
    input [31:0] acc;
    input [31:0] gx;
    input [31:0] gy;
    input [1:0] dir;
    begin
      case (dir)
        `TPI_STEP_RIGHT: step_acc = acc + gx;
        `TPI_STEP_LEFT: step_acc = acc - gx;
        `TPI_STEP_DOWN: step_acc = acc + gy;
        default: step_acc = acc - gy;
      endcase
    end
  endfunction

  // triangle sequencer
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  reg state_r;
  reg state_nxt;
  reg start_nxt;
  always @* begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_BUSY;
          start_nxt = 1'b1;
        end
      end
      ST_BUSY: begin
        if (tri_done_i)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // accumulators: load on accept, step while busy
  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      tri_start_o <= 1'b0;
      tri_busy_o <= 1'b0;
      tri_cw_o <= 1'b0;
      tri_ax_o <= 16'h0000;
      tri_ay_o <= 16'h0000;
      for (i = 0; i < 8; i = i + 1) begin
        acc_r[i] <= 32'h0;
        fgx_r[i] <= 32'h0;
        fgy_r[i] <= 32'h0;
      end
    end else begin
      state_r <= state_nxt;
      tri_start_o <= start_nxt;
      tri_busy_o <= (state_nxt == ST_BUSY);
      if (start_nxt) begin
        tri_cw_o <= wr_data_i[`TPI_CMD_SIGN_BIT];
        tri_ax_o <= vtx_ax_i;
        tri_ay_o <= vtx_ay_i;
        for (i = 0; i < 8; i = i + 1) begin
          acc_r[i] <= sx(start_r[i], i[2:0]);
          fgx_r[i] <= gx_r[i];
          fgy_r[i] <= gy_r[i];
        end
      end else if (tri_busy_o && !tri_done_i && step_en_i) begin
        for (i = 0; i < 8; i = i + 1) begin
          acc_r[i] <= step_acc(acc_r[i], fgx_r[i], fgy_r[i], step_dir_i);
        end
      end
    end
  end

  // signed v / (1/w) for a 2.30 reciprocal w, result in v's format
  function [31:0] persp_div;
    input [31:0] v;
    input [31:0] w;
    reg [31:0] den;
    reg [63:0] num;
    reg [63:0] quo;
    begin
      den = w[31] ? (32'h0 - w) : w;
      num = {{32{v[31]}}, v} << `TPI_FRAC_W;
      quo = 64'h0;
      if (den == 32'h0) begin
        persp_div = v;
      end else begin
        quo = $signed(num) / $signed({32'h0, den});
        if (w[31])
          persp_div = 32'h0 - quo[31:0];
        else
          persp_div = quo[31:0];
      end
    end
  endfunction

  // perspective divide of the iterated texture pair
  wire [31:0] s_div = persp_div(acc_r[`TPI_P_S], acc_r[`TPI_P_W]);
  wire [31:0] t_div = persp_div(acc_r[`TPI_P_T], acc_r[`TPI_P_W]);

  // colour field of an accumulator
  function [23:0] clr_field;
    input [31:0] v;
    begin
      clr_field = v[23:0];
    end
  endfunction

  // named accumulators
  wire [31:0] acc_red = acc_r[`TPI_P_R];
  wire [31:0] acc_green = acc_r[`TPI_P_G];
  wire [31:0] acc_blue = acc_r[`TPI_P_B];
  wire [31:0] acc_alpha = acc_r[`TPI_P_A];
  wire [31:0] acc_depth = acc_r[`TPI_P_Z];
  wire [31:0] acc_tex_s = acc_r[`TPI_P_S];
  wire [31:0] acc_tex_t = acc_r[`TPI_P_T];
  wire [31:0] acc_recip_w = acc_r[`TPI_P_W];

  // output next values
  reg [23:0] red_nxt;
  reg [23:0] green_nxt;
  reg [23:0] blue_nxt;
  reg [23:0] alpha_nxt;
  reg [31:0] depth_nxt;
  reg [31:0] tex_s_nxt;
  reg [31:0] tex_t_nxt;
  reg [31:0] recip_w_nxt;
  always @* begin
    red_nxt = clr_field(acc_red);
    green_nxt = clr_field(acc_green);
    blue_nxt = clr_field(acc_blue);
    alpha_nxt = clr_field(acc_alpha);
    depth_nxt = acc_depth;
    tex_s_nxt = persp_r ? s_div : acc_tex_s;
    tex_t_nxt = persp_r ? t_div : acc_tex_t;
    recip_w_nxt = acc_recip_w;
  end

  always @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      red_o <= 24'h0;
      green_o <= 24'h0;
      blue_o <= 24'h0;
      alpha_o <= 24'h0;
      depth_o <= 32'h0;
      tex_s_o <= 32'h0;
      tex_t_o <= 32'h0;
      recip_w_o <= 32'h0;
    end else begin
      red_o <= red_nxt;
      green_o <= green_nxt;
      blue_o <= blue_nxt;
      alpha_o <= alpha_nxt;
      depth_o <= depth_nxt;
      tex_s_o <= tex_s_nxt;
      tex_t_o <= tex_t_nxt;
      recip_w_o <= recip_w_nxt;
    end
  end

endmodule
`default_nettype wire

// file: bench/tpi_core_monitor.sv
`default_nettype none
module tpi_core_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host and step side
  input wire logic wr_en_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic step_en_i,
  input wire logic tri_done_i,
  // launch and params
  input wire logic tri_start_o,
  input wire logic tri_busy_o,
  input wire logic tri_cw_o,
  input wire logic [31:0] tex_s_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic cmd_w = wr_en_i && (wr_addr_i[5:1] == 5'h10);
  sequence s_accept;
    cmd_w && !tri_busy_o;
  endsequence
  sequence s_quiet;
    (!step_en_i && !wr_en_i)[*4];
  endsequence
  property p_start; s_accept |=> tri_start_o && tri_busy_o; endproperty
  property p_cw; s_accept |=> tri_cw_o == $past(wr_data_i[31]); endproperty
  property p_refuse; cmd_w && tri_busy_o |=> !tri_start_o; endproperty
  property p_pulse; tri_start_o |=> !tri_start_o; endproperty
  property p_busy; tri_busy_o && !tri_done_i |=> tri_busy_o; endproperty
  property p_done; tri_done_i && tri_busy_o |=> !tri_busy_o; endproperty
  property p_cwhold; tri_busy_o && !tri_start_o |-> $stable(tri_cw_o); endproperty
  property p_hold; s_quiet |-> $stable(tex_s_o); endproperty
  a_start: assert property (p_start) else $error("no launch");
  a_cw: assert property (p_cw) else $error("bad orientation");
  a_refuse: assert property (p_refuse) else $error("launch while busy");
  a_pulse: assert property (p_pulse) else $error("start too long");
  a_busy: assert property (p_busy) else $error("busy dropped");
  a_done: assert property (p_done) else $error("busy stuck");
  a_cwhold: assert property (p_cwhold) else $error("orientation moved");
  a_hold: assert property (p_hold) else $error("param drift");
endmodule
bind tpi_core tpi_core_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i),
  .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .step_en_i(step_en_i), .tri_done_i(tri_done_i),
  .tri_start_o(tri_start_o), .tri_busy_o(tri_busy_o), .tri_cw_o(tri_cw_o), .tex_s_o(tex_s_o));
`default_nettype wire

// file: bench/tpi_core_bench.sv
`default_nettype none
module tpi_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, nrst_i = 0, wr_en_i = 0, step_en_i = 0, tri_done_i = 0;
  logic [5:0] wr_addr_i = 0;
  logic [31:0] wr_data_i = 0;
  logic [15:0] vtx_ax_i = 16'h0123, vtx_ay_i = 16'hfe48;
  logic [1:0] step_dir_i = 0;
  wire logic tri_start_o, tri_busy_o, tri_cw_o;
  wire logic [15:0] tri_ax_o, tri_ay_o;
  wire logic [31:0] tex_s_o, tex_t_o, depth_o, recip_w_o;
  wire logic [23:0] red_o, green_o, blue_o, alpha_o;
  int bad_count = 0, cmp_count = 0;
  localparam logic [31:0] S0 = 32'hfffc_0000, S1 = 32'h0002_8000;
  localparam logic [31:0] GX = 32'h0000_1000, GY = 32'h0004_0800;
  tpi_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .vtx_ax_i(vtx_ax_i), .vtx_ay_i(vtx_ay_i), .step_en_i(step_en_i),
    .step_dir_i(step_dir_i), .tri_done_i(tri_done_i), .tri_start_o(tri_start_o),
    .tri_busy_o(tri_busy_o), .tri_cw_o(tri_cw_o), .tri_ax_o(tri_ax_o), .tri_ay_o(tri_ay_o),
    .red_o(red_o), .green_o(green_o), .blue_o(blue_o), .alpha_o(alpha_o), .depth_o(depth_o),
    .tex_s_o(tex_s_o), .tex_t_o(tex_t_o), .recip_w_o(recip_w_o));
  always #50 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wr_en_i = 1;
    wr_addr_i = a;
    wr_data_i = d;
    @(negedge clk_i);
  endtask
  task automatic step(input logic [1:0] d);
    step_en_i = 1;
    step_dir_i = d;
    @(negedge clk_i);
    step_en_i = 0;
    @(negedge clk_i);
  endtask
  task automatic t_launch;
    logic [31:0] acc;
    wr(6'h00, S0);
    wr(6'h15, GX);
    wr(6'h2d, GY);
    wr(6'h20, 32'h8000_1234);
    wr_en_i = 0;
    chk("start", 1, tri_start_o);
    chk("cw", 1, tri_cw_o);
    chk("ax", {16'h0, vtx_ax_i}, {16'h0, tri_ax_o});
    chk("ay", {16'h0, vtx_ay_i}, {16'h0, tri_ay_o});
    @(negedge clk_i);
    chk("s_start", S0, tex_s_o);
    acc = S0;
    for (int i = 0; i < 4; i++) begin
      step_en_i = 1;
      step_dir_i = 2'(i);
      @(negedge clk_i);
      step_en_i = 0;
      @(negedge clk_i);
      acc = (i == 0) ? acc + GX : (i == 1) ? acc - GX : (i == 2) ? acc + GY : acc - GY;
      chk("s_step", acc, tex_s_o);
    end
    $display("test launch done");
  endtask
  task automatic t_refuse;
    wr(6'h00, S1);
    wr(6'h21, 32'h0);
    wr_en_i = 0;
    chk("no_start", 0, tri_start_o);
    chk("cw_kept", 1, tri_cw_o);
    tri_done_i = 1;
    @(negedge clk_i);
    tri_done_i = 0;
    chk("idle", 0, tri_busy_o);
    wr(6'h21, 32'h7fff_ffff);
    wr_en_i = 0;
    chk("start2", 1, tri_start_o);
    chk("ccw", 0, tri_cw_o);
    @(negedge clk_i);
    chk("s_reload", S1, tex_s_o);
    $display("test refuse done");
  endtask
  task automatic t_params;
    tri_done_i = 1;
    @(negedge clk_i);
    tri_done_i = 0;
    wr(6'h03, 32'h0012_3000);
    wr(6'h06, 32'h3f00_0000);
    wr(6'h18, 32'h3f80_0000);
    wr(6'h11, 32'habff_f000);
    wr(6'h2b, 32'h0000_0800);
    wr(6'h2c, 32'h0000_2000);
    wr(6'h37, 32'hbe80_0000);
    wr(6'h22, 32'h0000_0001);
    wr(6'h20, 32'h0000_0000);
    wr_en_i = 0;
    @(negedge clk_i);
    chk("z_start", 32'h0012_3000, depth_o);
    chk("w_start", 32'h2000_0000, recip_w_o);
    chk("s_persp", 32'h0005_0000, tex_s_o);
    chk("g_start", 32'h0, {8'h0, green_o});
    step(2'h2);
    chk("z_dy", 32'h0012_5000, depth_o);
    chk("w_dy", 32'h1000_0000, recip_w_o);
    chk("a_dy", 32'h0000_0800, {8'h0, alpha_o});
    chk("s_dy", 32'h001a_2000, tex_s_o);
    step(2'h0);
    chk("r_dx", 32'h0000_1000, {8'h0, red_o});
    chk("g_dx", 32'h00ff_f000, {8'h0, green_o});
    chk("s_dx", 32'h001a_6000, tex_s_o);
    chk("t_dx", 32'h0, tex_t_o);
    chk("b_dx", 32'h0, {8'h0, blue_o});
    $display("test params done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1;
    repeat (3) @(negedge clk_i);
    t_launch;
    t_refuse;
    t_params;
    close_out;
  end
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
